// File: rtl/play_consts.svh
// Constants of the playback processing chain: register map, field positions, reset values, gain scaling
// Assumes it is included by bare name by the package and by every design module
// ==========================================================================
// Behaviour
// RULE1: The path sequencer mutes, switches and unmutes the paths itself, so no pops occur.
// RULE2: A submit write to either mode register makes the sequencer process both paths.
// RULE3: Each channel gain runs -78 dB to 12 dB in 0.75 dB steps; lowest mutes.
// RULE4: Each channel reports its active gain in a readable status value.
// RULE5: An IIR high-pass removes DC from both channels, below 2 Hz at lowest corner.
// RULE6: High-pass filters are enabled after reset and bypassed only when software clears enable.
// RULE7: Without voice mode a two-bit corner doubles the cutoff per code, scaling with rate.
// RULE8: Voice filtering needs voice enable and high-pass enable set; voice corner then applies.
// RULE9: A three-bit voice corner selects cutoffs from 2.5 Hz to 400 Hz at 8 kHz.
// RULE10: Software keeps voice mode off at sample rates above 16 kHz.
// RULE11: The equalizer has five fixed bands, each -10.5 dB to 12 dB in 1.5 dB steps.
// RULE12: One equalizer enable switches the equalizer for both channels together.
// RULE13: An enabled equalizer lowers the path gain by 12 dB for headroom.
// RULE14: Software keeps the equalizer off above 48 kHz; band centres scale with rate.
// RULE15: Soft mute ramps gain down in 0.1875 dB steps to -77.25 dB, then silences.
// RULE16: Releasing soft mute starts at -77.25 dB and ramps up to the prior gain.
// RULE17: The soft-mute enable mutes both channels at the same time.
// RULE18: Soft-mute ramp step rate follows the audio sample rate.
// RULE19: During soft mute the applied gain may differ from the reported gain status.
// RULE20: Settings change only on sample boundaries, never within one sample.
`ifndef PLAY_CONSTS_SVH
`define PLAY_CONSTS_SVH
// ==========================================================================
// Register offsets
`define OFS_MODE_IN 8'h00
`define OFS_MODE_OUT 8'h04
`define OFS_FILT 8'h08
`define OFS_EQ 8'h0c
`define OFS_GAIN_L 8'h10
`define OFS_GAIN_R 8'h14
`define OFS_MUTE 8'h18
`define OFS_STAT_L 8'h1c
`define OFS_STAT_R 8'h20
`define OFS_SEQ 8'h24
// ==========================================================================
// Fields
`define MODE_EN_BIT 0
`define MODE_SUBMIT_BIT 7
`define FILT_HPF_EN_BIT 0
`define FILT_AUD_LSB 1
`define FILT_VOICE_BIT 3
`define FILT_VCORN_LSB 4
`define FILT_EQ_EN_BIT 7
`define MUTE_EN_BIT 0
`define MUTE_RATE_LSB 1
// ==========================================================================
// Reset values
`define FILT_RESET 8'h01
`define EQ_RESET 20'h77777
`define GAIN_RESET 7'h68
// ==========================================================================
// Gain scale in 0.1875 dB units, 0 is full mute, 416 is 0 dB
`define Q_FLOOR 10'h004
`define Q_HEADROOM 10'h040
`define EQ_Q_BASE 10'h168
`define EQ_Q_STEP 10'h008
`define SCALE_SHIFT 5'h12
`define AUD_K_BASE 4'hc
`define EQ_SPLIT_K 16'h357a
`endif

// File: rtl/play_pkg.sv
// Types of the playback processing chain
// Assumes the constants header sits on the include path
`include "play_consts.svh"
package play_pkg;
   typedef enum logic [3:0] {SEQ_IDLE = 4'h1, SEQ_DOWN = 4'h2, SEQ_APPLY = 4'h4, SEQ_UP = 4'h8} seq_st_t;
   typedef enum logic [3:0] {MU_OFF = 4'h1, MU_DOWN = 4'h2, MU_ON = 4'h4, MU_UP = 4'h8} mute_st_t;
   typedef struct packed {
      logic aw_rdy;
      logic w_rdy;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_adr;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_rdy;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [6:0] mode_in;
      logic [6:0] mode_out;
      logic [7:0] filt;
      logic [19:0] eq;
      logic [1:0][6:0] gain;
      logic [2:0] mute;
      logic [7:0] filt_a;
      logic [19:0] eq_a;
      logic [1:0][6:0] gain_a;
      logic [1:0][9:0] aq;
      logic [2:0] tick;
      mute_st_t mst;
      seq_st_t sst;
      logic seq_mute;
      logic pend;
      logic out_en;
      logic in_en;
      logic dvld;
   } core_st_t;
endpackage

// File: rtl/play_chan.sv
// One playback channel: DC-removing high-pass, five-band equalizer, gain stage
// Assumes settings are already held steady by the caller between sample strobes
`timescale 1ns/1ps
`include "play_consts.svh"
module play_chan
   import play_pkg::*;
#(
   parameter int SW = 24
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stb_i,
   input wire logic signed [SW-1:0] smp_i,
   input wire logic hpf_en_i,
   input wire logic [3:0] hpf_k_i,
   input wire logic eq_en_i,
   input wire logic [19:0] eq_gain_i,
   input wire logic [9:0] gain_q_i,
   output logic signed [SW-1:0] smp_o
);
   localparam logic [15:0] EQ_K = `EQ_SPLIT_K;
   localparam logic signed [31:0] SMAX = (32'sh1 <<< (SW - 1)) - 32'sh1;
   localparam logic signed [31:0] SMIN = -SMAX - 32'sh1;
   typedef struct packed {
      logic signed [31:0] x1;
      logic signed [31:0] y1;
      logic [3:0][31:0] lp;
      logic signed [SW-1:0] out;
   } chan_st_t;
   chan_st_t s_ff;
   chan_st_t nxt_s;

   // ==========================================================================
   // Gain of 2^((q-416)/32); mantissa is a linear fit, within half a dB
   function automatic logic signed [31:0] scale(input logic signed [31:0] x, input logic [9:0] q);
      logic signed [55:0] p;
      logic [6:0] m;
      m = 7'h20 + {2'h0, q[4:0]};
      p = 56'(x) * $signed({1'b0, m});
      p = p <<< q[9:5];
      scale = (q == 10'h000) ? 32'sh0 : 32'(p >>> `SCALE_SHIFT); // RULE3
   endfunction

   // ==========================================================================
   // Datapath, one sample per strobe
   always_comb
   begin
      logic signed [31:0] d;
      logic signed [31:0] acc;
      logic signed [31:0] g;
      logic signed [31:0] tap [6];
      nxt_s = s_ff;
      d = 32'(smp_i);
      if (hpf_en_i)
      begin
         // Cutoff is a fixed fraction of the sample rate, so corners track the rate
         d = d - s_ff.x1 + s_ff.y1 - (s_ff.y1 >>> hpf_k_i); // RULE5 RULE7
      end
      tap[0] = 32'sh0;
      for (int i = 0; i < 4; i++)
      begin
         tap[i + 1] = $signed(s_ff.lp[i]);
      end
      tap[5] = d;
      acc = d;
      if (eq_en_i)
      begin
         acc = 32'sh0;
         for (int i = 0; i < 5; i++)
         begin
            acc = acc + scale(tap[i + 1] - tap[i], `EQ_Q_BASE + 10'(eq_gain_i[4*i +: 4]) * `EQ_Q_STEP); // RULE11
         end
      end
      g = scale(acc, gain_q_i);
      if (stb_i)
      begin
         nxt_s.x1 = 32'(smp_i);
         nxt_s.y1 = hpf_en_i ? d : 32'sh0;
         for (int i = 0; i < 4; i++)
         begin
            nxt_s.lp[i] = 32'($signed(s_ff.lp[i]) + ((d - $signed(s_ff.lp[i])) >>> EQ_K[4*i +: 4]));
         end
         nxt_s.out = (g > SMAX) ? SW'(SMAX) : (g < SMIN) ? SW'(SMIN) : SW'(g);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end

   assign smp_o = s_ff.out;
endmodule

// File: rtl/play_chain.sv
// Playback processing chain: register slave, path sequencer, soft mute, two channel datapaths
// Assumes samples and register bus share clk_i; the router strobes one stereo sample at a time
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "play_consts.svh"
module play_chain
   import play_pkg::*;
#(
   parameter int SW = 24
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [7:0] awaddr_i,
   input wire logic wvalid_i,
   output logic wready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   output logic bvalid_o,
   input wire logic bready_i,
   output logic [1:0] bresp_o,
   input wire logic arvalid_i,
   output logic arready_o,
   input wire logic [7:0] araddr_i,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   input wire logic smp_valid_i,
   input wire logic signed [SW-1:0] smp_l_i,
   input wire logic signed [SW-1:0] smp_r_i,
   output logic dac_valid_o,
   output logic signed [SW-1:0] dac_l_o,
   output logic signed [SW-1:0] dac_r_o,
   output logic out_path_en_o,
   output logic in_path_en_o
);
   core_st_t s_ff;
   core_st_t nxt_s;
   logic eff_mute;
   logic step;
   logic [1:0][9:0] tq;
   logic [3:0] hpf_k;
   logic signed [SW-1:0] ch_in [2];
   logic signed [SW-1:0] ch_out [2];
   logic [9:0] ch_q [2];

   // ==========================================================================
   // Byte-lane merge for register writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] stb);
      merge = old;
      for (int b = 0; b < 4; b++)
      begin
         if (stb[b])
            merge[8*b +: 8] = d[8*b +: 8];
      end
   endfunction

   // ==========================================================================
   // Voice corner: shift that puts the corner near the tabled cutoff
   function automatic logic [3:0] voice_k(input logic [2:0] c);
      unique case (c)
         3'h0: voice_k = 4'h9;
         3'h1: voice_k = 4'h6;
         3'h2: voice_k = 4'h5;
         3'h3: voice_k = 4'h4;
         3'h4: voice_k = 4'h3;
         3'h5: voice_k = 4'h3;
         3'h6: voice_k = 4'h2;
         3'h7: voice_k = 4'h2;
      endcase
   endfunction

   // ==========================================================================
   // Settings in force, taken from the shadow copy
   always_comb
   begin
      if (s_ff.filt_a[`FILT_VOICE_BIT])
         hpf_k = voice_k(s_ff.filt_a[`FILT_VCORN_LSB +: 3]); // RULE8 RULE9
      else
         hpf_k = `AUD_K_BASE - {2'h0, s_ff.filt_a[`FILT_AUD_LSB +: 2]}; // RULE7
   end

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         tq[c] = {1'b0, s_ff.gain_a[c], 2'h0}; // RULE3
         if (s_ff.filt_a[`FILT_EQ_EN_BIT])
            tq[c] = (tq[c] > `Q_HEADROOM) ? tq[c] - `Q_HEADROOM : 10'h000; // RULE13
      end
   end

   assign eff_mute = s_ff.mute[`MUTE_EN_BIT] | s_ff.seq_mute; // RULE17
   assign step = smp_valid_i && (s_ff.tick == 3'h0); // RULE18

   // ==========================================================================
   // Next state
   always_comb
   begin
      logic [2:0] div;
      logic all_low;
      logic all_at;
      nxt_s = s_ff;
      div = 3'((4'h1 << s_ff.mute[`MUTE_RATE_LSB +: 2]) - 4'h1);
      all_low = 1'b1;
      all_at = 1'b1;
      nxt_s.dvld = smp_valid_i;

      // Shadow copies move only at a sample strobe
      if (smp_valid_i)
      begin
         nxt_s.filt_a = s_ff.filt; // RULE20
         nxt_s.eq_a = s_ff.eq;
         nxt_s.gain_a = s_ff.gain;
         nxt_s.tick = (s_ff.tick == 3'h0) ? div : s_ff.tick - 3'h1;
      end

      // Soft mute ramp, both channels in lock step
      for (int c = 0; c < 2; c++)
      begin
         if (s_ff.aq[c] > `Q_FLOOR)
            all_low = 1'b0;
         if (s_ff.aq[c] != tq[c])
            all_at = 1'b0;
      end
      unique case (s_ff.mst)
         MU_OFF:
         begin
            if (smp_valid_i)
               nxt_s.aq = tq;
            if (eff_mute)
               nxt_s.mst = MU_DOWN;
         end
         MU_DOWN:
         begin
            if (!eff_mute)
               nxt_s.mst = MU_UP;
            else if (step && all_low)
            begin
               nxt_s.aq = '0; // RULE15
               nxt_s.mst = MU_ON;
            end
            else if (step)
            begin
               for (int c = 0; c < 2; c++)
               begin
                  if (s_ff.aq[c] > `Q_FLOOR)
                     nxt_s.aq[c] = s_ff.aq[c] - 10'h001; // RULE15 RULE17
               end
            end
         end
         MU_ON:
         begin
            if (!eff_mute)
            begin
               for (int c = 0; c < 2; c++)
               begin
                  nxt_s.aq[c] = (tq[c] < `Q_FLOOR) ? tq[c] : `Q_FLOOR; // RULE16
               end
               nxt_s.mst = MU_UP;
            end
         end
         MU_UP:
         begin
            if (eff_mute)
               nxt_s.mst = MU_DOWN;
            else if (step && all_at)
               nxt_s.mst = MU_OFF;
            else if (step)
            begin
               for (int c = 0; c < 2; c++)
               begin
                  nxt_s.aq[c] = (s_ff.aq[c] < tq[c]) ? s_ff.aq[c] + 10'h001 : tq[c]; // RULE16
               end
            end
         end
      endcase

      // Path sequencer: mute, switch, unmute; stalls if samples stop arriving
      unique case (s_ff.sst)
         SEQ_IDLE:
         begin
            if (s_ff.pend)
            begin
               nxt_s.pend = 1'b0;
               nxt_s.seq_mute = 1'b1; // RULE1
               nxt_s.sst = SEQ_DOWN;
            end
         end
         SEQ_DOWN:
         begin
            if (s_ff.mst == MU_ON)
               nxt_s.sst = SEQ_APPLY;
         end
         SEQ_APPLY:
         begin
            nxt_s.out_en = s_ff.mode_out[`MODE_EN_BIT]; // RULE2
            nxt_s.in_en = s_ff.mode_in[`MODE_EN_BIT]; // RULE2
            nxt_s.seq_mute = 1'b0;
            nxt_s.sst = SEQ_UP;
         end
         SEQ_UP:
         begin
            if (s_ff.mst == MU_OFF || s_ff.mute[`MUTE_EN_BIT])
               nxt_s.sst = SEQ_IDLE;
         end
      endcase

      // Write channel; address and data may come in either order
      if (awvalid_i && s_ff.aw_rdy)
      begin
         nxt_s.aw_got = 1'b1;
         nxt_s.aw_adr = awaddr_i;
      end
      if (wvalid_i && s_ff.w_rdy)
      begin
         nxt_s.w_got = 1'b1;
         nxt_s.wdat = wdata_i;
         nxt_s.wstb = wstrb_i;
      end
      if (s_ff.bvalid && bready_i)
         nxt_s.bvalid = 1'b0;
      if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid)
      begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = 2'h0;
         unique case (s_ff.aw_adr)
            `OFS_MODE_IN, `OFS_MODE_OUT:
            begin
               if (s_ff.aw_adr == `OFS_MODE_IN)
                  nxt_s.mode_in = 7'(merge({25'h0, s_ff.mode_in}, s_ff.wdat, s_ff.wstb));
               else
                  nxt_s.mode_out = 7'(merge({25'h0, s_ff.mode_out}, s_ff.wdat, s_ff.wstb));
               // A new submit stays pending even if the sequencer clears it now
               if (s_ff.wstb[0] && s_ff.wdat[`MODE_SUBMIT_BIT])
                  nxt_s.pend = 1'b1; // RULE2
            end
            `OFS_FILT: nxt_s.filt = 8'(merge({24'h0, s_ff.filt}, s_ff.wdat, s_ff.wstb)); // RULE6 RULE12
            `OFS_EQ: nxt_s.eq = 20'(merge({12'h0, s_ff.eq}, s_ff.wdat, s_ff.wstb));
            `OFS_GAIN_L: nxt_s.gain[0] = 7'(merge({25'h0, s_ff.gain[0]}, s_ff.wdat, s_ff.wstb));
            `OFS_GAIN_R: nxt_s.gain[1] = 7'(merge({25'h0, s_ff.gain[1]}, s_ff.wdat, s_ff.wstb));
            `OFS_MUTE: nxt_s.mute = 3'(merge({29'h0, s_ff.mute}, s_ff.wdat, s_ff.wstb));
            `OFS_STAT_L, `OFS_STAT_R, `OFS_SEQ: nxt_s.bresp = 2'h0;
            default: nxt_s.bresp = 2'h2;
         endcase
      end
      nxt_s.aw_rdy = !nxt_s.aw_got && !nxt_s.bvalid;
      nxt_s.w_rdy = !nxt_s.w_got && !nxt_s.bvalid;

      // Read channel, one cycle from address to data
      if (s_ff.rvalid && rready_i)
      begin
         nxt_s.rvalid = 1'b0;
         nxt_s.ar_rdy = 1'b1;
      end
      if (arvalid_i && s_ff.ar_rdy)
      begin
         nxt_s.ar_rdy = 1'b0;
         nxt_s.rvalid = 1'b1;
         nxt_s.rresp = 2'h0;
         nxt_s.rdata = 32'h0;
         unique case (araddr_i)
            `OFS_MODE_IN: nxt_s.rdata = {25'h0, s_ff.mode_in};
            `OFS_MODE_OUT: nxt_s.rdata = {25'h0, s_ff.mode_out};
            `OFS_FILT: nxt_s.rdata = {24'h0, s_ff.filt};
            `OFS_EQ: nxt_s.rdata = {12'h0, s_ff.eq};
            `OFS_GAIN_L: nxt_s.rdata = {25'h0, s_ff.gain[0]};
            `OFS_GAIN_R: nxt_s.rdata = {25'h0, s_ff.gain[1]};
            `OFS_MUTE: nxt_s.rdata = {29'h0, s_ff.mute};
            // Status shows the gain in force, not the ramped one
            `OFS_STAT_L: nxt_s.rdata = {25'h0, s_ff.gain_a[0]}; // RULE4 RULE19
            `OFS_STAT_R: nxt_s.rdata = {25'h0, s_ff.gain_a[1]}; // RULE4 RULE19
            `OFS_SEQ: nxt_s.rdata = {27'h0, s_ff.mst == MU_ON, s_ff.mst != MU_OFF, s_ff.in_en, s_ff.out_en,
                                     s_ff.sst != SEQ_IDLE || s_ff.pend};
            default: nxt_s.rresp = 2'h2;
         endcase
      end
   end

   // ==========================================================================
   // State register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_ff <= '0;
         s_ff.aw_rdy <= 1'b1;
         s_ff.w_rdy <= 1'b1;
         s_ff.ar_rdy <= 1'b1;
         s_ff.filt <= `FILT_RESET; // RULE6
         s_ff.filt_a <= `FILT_RESET; // RULE6
         s_ff.eq <= `EQ_RESET;
         s_ff.eq_a <= `EQ_RESET;
         s_ff.gain <= {`GAIN_RESET, `GAIN_RESET};
         s_ff.gain_a <= {`GAIN_RESET, `GAIN_RESET};
         s_ff.mst <= MU_OFF;
         s_ff.sst <= SEQ_IDLE;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================================================
   // Channel datapaths; a path that is off runs at full mute
   assign ch_in[0] = smp_l_i;
   assign ch_in[1] = smp_r_i;
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      assign ch_q[c] = s_ff.out_en ? s_ff.aq[c] : 10'h000; // RULE1
      play_chan #(.SW(SW)) u_chan
      (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .stb_i(smp_valid_i),
         .smp_i(ch_in[c]),
         .hpf_en_i(s_ff.filt_a[`FILT_HPF_EN_BIT]), // RULE6
         .hpf_k_i(hpf_k),
         .eq_en_i(s_ff.filt_a[`FILT_EQ_EN_BIT]), // RULE12
         .eq_gain_i(s_ff.eq_a),
         .gain_q_i(ch_q[c]),
         .smp_o(ch_out[c])
      );
   end

   assign dac_l_o = ch_out[0];
   assign dac_r_o = ch_out[1];
   assign dac_valid_o = s_ff.dvld;
   assign out_path_en_o = s_ff.out_en;
   assign in_path_en_o = s_ff.in_en;
   assign awready_o = s_ff.aw_rdy;
   assign wready_o = s_ff.w_rdy;
   assign bvalid_o = s_ff.bvalid;
   assign bresp_o = s_ff.bresp;
   assign arready_o = s_ff.ar_rdy;
   assign rvalid_o = s_ff.rvalid;
   assign rdata_o = s_ff.rdata;
   assign rresp_o = s_ff.rresp;
endmodule

// File: testbench/play_chain_props.sv
// Port checker for the playback chain
// Assumes binding to play_chain; watches only its ports
`timescale 1ns/1ps
module play_chain_chk
   import play_pkg::*;
#(
   parameter int SW = 24
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic awvalid_i,
   input wire logic awready_o,
   input wire logic wvalid_i,
   input wire logic wready_o,
   input wire logic bvalid_o,
   input wire logic bready_i,
   input wire logic [1:0] bresp_o,
   input wire logic arvalid_i,
   input wire logic arready_o,
   input wire logic rvalid_o,
   input wire logic rready_i,
   input wire logic [31:0] rdata_o,
   input wire logic smp_valid_i,
   input wire logic dac_valid_o,
   input wire logic signed [SW-1:0] dac_l_o,
   input wire logic signed [SW-1:0] dac_r_o,
   input wire logic out_path_en_o,
   input wire logic in_path_en_o
);
   // ==========================================================
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wr_taken;
      awvalid_i && awready_o && wvalid_i && wready_o;
   endsequence
   sequence s_rd_taken;
      arvalid_i && arready_o;
   endsequence
   a_wr_answer: assert property (s_wr_taken |=> ##1 bvalid_o) else $error("write not answered");
   a_b_stands: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o)) else $error("b dropped");
   a_aw_blocked: assert property (bvalid_o |-> !awready_o && !wready_o) else $error("write taken early");
   a_rd_answer: assert property (s_rd_taken |=> rvalid_o && !arready_o) else $error("read not answered");
   a_r_stands: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o)) else $error("r dropped");
   a_dac_follows: assert property (smp_valid_i |=> dac_valid_o) else $error("sample lost");
   a_dac_cause: assert property (dac_valid_o |-> $past(smp_valid_i)) else $error("stray sample");
   a_dac_hold: assert property (!$past(smp_valid_i) |-> $stable(dac_l_o) && $stable(dac_r_o))
      else $error("output moved between samples");
   a_off_silent: assert property (dac_valid_o && !out_path_en_o |-> dac_l_o == '0 && dac_r_o == '0)
      else $error("output while path off");
   a_reset_idle: assert property (disable iff (1'b0) rst_i |=> awready_o && arready_o && !bvalid_o
      && !rvalid_o && !dac_valid_o && !out_path_en_o && !in_path_en_o) else $error("reset state wrong");
endmodule
bind play_chain play_chain_chk #(.SW(SW)) chk (.clk_i, .rst_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o,
   .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .rvalid_o, .rready_i, .rdata_o, .smp_valid_i,
   .dac_valid_o, .dac_l_o, .dac_r_o, .out_path_en_o, .in_path_en_o);

// File: testbench/router_model.sv
// Router side model: one stereo strobe every fourth clock
// Assumes a fixed sample period; no rate change mid-run
`timescale 1ns/1ps
module router_model
   import play_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic signed [23:0] val_i,
   output logic smp_valid_o,
   output logic signed [23:0] smp_l_o,
   output logic signed [23:0] smp_r_o
);
   // ==========================================================
   // Strobe source; data off-strobe is inverted so it is never mistaken for valid
   logic [1:0] cnt_ff;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_ff <= 2'h0;
         smp_valid_o <= 1'b0;
         smp_l_o <= 24'h0;
         smp_r_o <= 24'h0;
      end
      else
      begin
         cnt_ff <= cnt_ff + 2'h1;
         smp_valid_o <= (cnt_ff == 2'h3);
         smp_l_o <= (cnt_ff == 2'h3) ? val_i : ~smp_l_o;
         smp_r_o <= (cnt_ff == 2'h3) ? val_i : ~smp_r_o;
      end
   end
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the playback chain
// Assumes play_consts.svh on the include path and the router model beside it
`timescale 1ns/1ps
`include "play_consts.svh"
module testbench
   import play_pkg::*;
;
   // ==========================================================
   // Signals
   localparam logic signed [23:0] X = 24'sh100000;
   localparam int RAMP = 450;
   logic clk_i, rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, smp_valid_i;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, dac_valid_o, out_path_en_o, in_path_en_o;
   logic [7:0] awaddr_i, araddr_i;
   logic [31:0] wdata_i, rdata_o, d;
   logic [3:0] wstrb_i;
   logic [1:0] bresp_o, rresp_o, r;
   logic signed [23:0] smp_l_i, smp_r_i, dac_l_o, dac_r_o, v = X;
   int n_fail, num_checks, cyc;
   logic [7:0] ra [11] = '{`OFS_MODE_IN, `OFS_MODE_OUT, `OFS_FILT, `OFS_EQ, `OFS_GAIN_L, `OFS_GAIN_R,
      `OFS_MUTE, `OFS_STAT_L, `OFS_STAT_R, 8'h28, `OFS_SEQ};
   logic [33:0] rv [11] = '{0, 0, `FILT_RESET, `EQ_RESET, `GAIN_RESET, `GAIN_RESET, 0, `GAIN_RESET,
      `GAIN_RESET, {2'h2, 32'h0}, 0};
   router_model prt (.clk_i(clk_i), .rst_i(rst_i), .val_i(v), .smp_valid_o(smp_valid_i), .smp_l_o(smp_l_i),
      .smp_r_o(smp_r_i));
   play_chain #(.SW(24)) uut (.clk_i, .rst_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o,
      .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o, .araddr_i, .rvalid_o,
      .rready_i, .rdata_o, .rresp_o, .smp_valid_i, .smp_l_i, .smp_r_i, .dac_valid_o, .dac_l_o, .dac_r_o,
      .out_path_en_o, .in_path_en_o);
   // ==========================================================
   // Tasks
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD t=%0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic rng(input logic signed [23:0] g, input int lo, input int hi);
      num_checks++;
      if ((g >= lo && g <= hi) !== 1'b1)
      begin
         n_fail++;
         $display("BAD t=%0t %0d outside %0d..%0d", $time, g, lo, hi);
      end
   endtask
   // Response is awaited late on purpose so the slave must hold it
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      awaddr_i <= a;
      wdata_i <= v;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      do
      begin
         @(posedge clk_i);
         if (pa && awready_o)
         begin
            awvalid_i <= 1'b0;
            pa = 1'b0;
         end
         if (pw && wready_o)
         begin
            wvalid_i <= 1'b0;
            pw = 1'b0;
         end
      end
      while (pa || pw);
      repeat (2) @(posedge clk_i);
      bready_i <= 1'b1;
      do @(posedge clk_i); while (!bvalid_o);
      bready_i <= 1'b0;
      chk(bresp_o, e);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      do @(posedge clk_i); while (!arready_o);
      arvalid_i <= 1'b0;
      @(posedge clk_i);
      rready_i <= 1'b1;
      do @(posedge clk_i); while (!rvalid_o);
      d = rdata_o;
      r = rresp_o;
      rready_i <= 1'b0;
   endtask
   task automatic ns(input int n);
      repeat (n) @(posedge clk_i iff dac_valid_o);
   endtask
   task automatic ws(input logic [31:0] m, input logic [31:0] v);
      do rd(`OFS_SEQ); while ((d & m) !== v);
   endtask
   // ==========================================================
   // Clock, timeout, sequence
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         give_verdict;
      end
   end
   initial
   begin
      {rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 6'h20;
      {awaddr_i, araddr_i, wdata_i, wstrb_i} = {16'h0, 32'h0, 4'hf};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 11; i++)
      begin
         rd(ra[i]);
         chk({r, d}, rv[i]);
      end
      wr(`OFS_STAT_L, 32'h11, 2'h0);
      wr(8'h28, 32'h5, 2'h2);
      rd(`OFS_STAT_L);
      chk(d, `GAIN_RESET);
      wr(`OFS_GAIN_L, 32'h50, 2'h0);
      ns(2);
      rd(`OFS_STAT_L);
      chk(d, 32'h50);
      wr(`OFS_GAIN_L, `GAIN_RESET, 2'h0);
      wr(`OFS_FILT, 32'h0, 2'h0);
      wr(`OFS_MODE_IN, 32'h1, 2'h0);
      wr(`OFS_MODE_OUT, 32'h81, 2'h0);
      ws(32'h9, 32'h0);
      chk({out_path_en_o, in_path_en_o}, 2'h3);
      rd(`OFS_MODE_OUT);
      chk(d, 32'h1);
      ns(RAMP);
      chk(dac_l_o, X);
      wr(`OFS_GAIN_L, 32'h0, 2'h0);
      ns(RAMP);
      chk(dac_l_o, 24'h0);
      chk(dac_r_o, X);
      wr(`OFS_GAIN_L, `GAIN_RESET, 2'h0);
      wr(`OFS_FILT, 32'h80, 2'h0);
      ns(RAMP);
      rng(dac_l_o, X / 4 - X / 16, X / 4 + X / 16);
      rng(dac_r_o, X / 4 - X / 16, X / 4 + X / 16);
      wr(`OFS_EQ, 32'h99999, 2'h0);
      ns(3);
      rng(dac_l_o, 3 * X / 8 - 16, 3 * X / 8 + 16);
      wr(`OFS_FILT, 32'h7, 2'h0);
      ns(2);
      // A filter switched on under steady DC shows no step, so step the input
      v <= 24'sh0;
      ns(100);
      rng(dac_l_o, -7 * X / 8, -3 * X / 4);
      wr(`OFS_FILT, 32'h79, 2'h0);
      ns(100);
      rng(dac_l_o, -X / 64, X / 64);
      v <= X;
      wr(`OFS_FILT, 32'h0, 2'h0);
      ns(3);
      chk(dac_l_o, X);
      wr(`OFS_MUTE, 32'h1, 2'h0);
      ns(40);
      rng(dac_l_o, X / 64, X - 1);
      ws(32'h10, 32'h10);
      ns(2);
      chk(dac_l_o, 24'h0);
      chk(dac_r_o, 24'h0);
      rd(`OFS_STAT_L);
      chk(d, `GAIN_RESET);
      wr(`OFS_MUTE, 32'h0, 2'h0);
      ns(5);
      rng(dac_l_o, 0, X / 512);
      ws(32'h8, 32'h0);
      ns(2);
      chk(dac_l_o, X);
      wr(`OFS_MUTE, 32'h3, 2'h0);
      ns(200);
      rng(dac_l_o, X / 16, X - 1);
      wr(`OFS_MUTE, 32'h0, 2'h0);
      give_verdict;
   end
endmodule
